// ### src/rcf_axil_slave.sv
// axi4-lite slave front end: handshakes, one write and one read at a time
`timescale 1ns/1ps
module rcf_axil_slave
    import rcf_pkg::*;
(
    input wire logic i_clk, // system clock
    input wire logic i_rst_b, // synchronised reset, active low
    input wire logic i_awvalid, // write address valid
    output logic o_awready, // write address ready
    input wire logic [rcf_pkg::ADDR_W-1:0] i_awaddr, // write byte address
    input wire logic i_wvalid, // write data valid
    output logic o_wready, // write data ready
    input wire logic [rcf_pkg::DATA_W-1:0] i_wdata, // write data
    input wire logic [3:0] i_wstrb, // write byte strobes
    output logic o_bvalid, // write response valid
    input wire logic i_bready, // write response ready
    output logic [1:0] o_bresp, // write response
    input wire logic i_arvalid, // read address valid
    output logic o_arready, // read address ready
    input wire logic [rcf_pkg::ADDR_W-1:0] i_araddr, // read byte address
    output logic o_rvalid, // read data valid
    input wire logic i_rready, // read data ready
    output logic [rcf_pkg::DATA_W-1:0] o_rdata, // read data
    output logic [1:0] o_rresp, // read response
    output logic o_wr_en, // register write strobe, one cycle
    output logic [9:0] o_wr_idx, // register index of the write
    output logic [7:0] o_wr_data, // low byte of write data
    output logic o_wr_lane0, // byte lane 0 enabled
    input wire logic i_wr_hit, // write index is mapped
    output logic [9:0] o_rd_idx, // register index being read
    input wire logic [7:0] i_rd_data, // register value at o_rd_idx
    input wire logic i_rd_hit // read index is mapped
);
    logic aw_have_q;
    logic w_have_q;

    assign o_wr_en = aw_have_q & w_have_q & ~o_bvalid;
    assign o_rd_idx = i_araddr[ADDR_W-1:2];

    // address and data taken in either order, held until both are here
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_awready <= 1'b0;
            o_wready <= 1'b0;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            o_wr_idx <= '0;
            o_wr_data <= '0;
            o_wr_lane0 <= 1'b0;
        end else begin
            o_awready <= i_awvalid & ~o_awready & ~aw_have_q & ~o_bvalid;
            o_wready <= i_wvalid & ~o_wready & ~w_have_q & ~o_bvalid;
            if (i_awvalid && o_awready) begin
                aw_have_q <= 1'b1;
                o_wr_idx <= i_awaddr[ADDR_W-1:2];
            end else if (o_wr_en) begin
                aw_have_q <= 1'b0;
            end
            if (i_wvalid && o_wready) begin
                w_have_q <= 1'b1;
                o_wr_data <= i_wdata[7:0];
                o_wr_lane0 <= i_wstrb[0];
            end else if (o_wr_en) begin
                w_have_q <= 1'b0;
            end
        end
    end

    // write response, unmapped index answers slverr
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_bvalid <= 1'b0;
            o_bresp <= RESP_OKAY;
        end else if (o_wr_en) begin
            o_bvalid <= 1'b1;
            o_bresp <= i_wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (i_bready) begin
            o_bvalid <= 1'b0;
        end
    end

    // read path; araddr is stable while arvalid stands, so the value is safe to sample
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= '0;
            o_rresp <= RESP_OKAY;
        end else begin
            o_arready <= i_arvalid & ~o_arready & ~o_rvalid;
            if (i_arvalid && o_arready) begin
                o_rvalid <= 1'b1;
                o_rdata <= {24'h0, i_rd_data};
                o_rresp <= i_rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end
endmodule : rcf_axil_slave

// ### src/rcf_pkg.sv
// package with register map, field layout and reset values of the reset cause flags block
package rcf_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_BROWNOUT_CONTROL = 10'h191;
    localparam logic [9:0] IDX_RESET_CAUSE_FLAGS = 10'h192;
    localparam logic [9:0] IDX_RESET_CAUSE_FLAGS_EXT = 10'h193;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h194;
    localparam logic [9:0] IDX_IRQ_ENABLE = 10'h195;
    localparam logic [9:0] IDX_IRQ_CLEAR = 10'h196;
    // reset_cause_flags fields
    localparam int BIT_STACK_OVERFLOW = 7;
    localparam int BIT_STACK_UNDERFLOW = 6;
    localparam int BIT_WDT_WINDOW = 5;
    localparam int BIT_WDT_TIMEOUT = 4;
    localparam int BIT_EXT_PIN = 3;
    localparam int BIT_RESET_INSTR = 2;
    localparam int BIT_POWER_ON = 1;
    localparam int BIT_BROWNOUT = 0;
    // reset_cause_flags_ext and brownout_control fields
    localparam int BIT_MEM_VIOLATION = 1;
    localparam int BIT_SW_BOR_ENABLE = 7;
    localparam int BIT_BOR_READY = 0;
    // interrupt status layout, one bit per reset cause event
    localparam int IRQ_STACK_OVERFLOW = 7;
    localparam int IRQ_STACK_UNDERFLOW = 6;
    localparam int IRQ_WDT_WINDOW = 5;
    localparam int IRQ_WDT_TIMEOUT = 4;
    localparam int IRQ_EXT_PIN = 3;
    localparam int IRQ_RESET_INSTR = 2;
    localparam int IRQ_MEM_VIOLATION = 1;
    localparam int IRQ_BROWNOUT = 0;
    // values after power-on (brown-out flag value is a parameter of the top), masks and response codes
    localparam logic [7:0] FLAGS_POR_VAL = 8'h3c;
    localparam logic [7:0] FLAGS_BOR_MASK = 8'hfc;
    localparam logic [7:0] EXT_MASK = 8'h02;
    localparam logic [7:0] BROWNOUT_CONTROL_WR_MASK = 8'h80;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : rcf_pkg

// ### src/rcf_reset_cause_flags.sv
// reset cause flags: sticky restart-cause record with axi4-lite access and interrupt
// Functional notes
// - stack underflow sets flag; power-on/brown-out clear
// - window violation clears flag; initialised to one
// - watchdog time-out clears flag; initialised to one
// - external pin reset clears flag; initialised one
// - reset instruction clears flag; initialised to one
// - power-on clears power-on flag only
// - brown-out clears brown-out flag only
// - memory violation clears ext bit 1
// - other resets update only matching flag
// - three byte registers at 191,192,193
// - flag order bit 7 down to 0
// - stack overflow sets bit 7; power-on clears
// - only the firing cause's flag changes; brown-out here also reloads bits 7 to 2 and sets ext bit 1
// - software active writes stored, no reset
// - brownout control: enable bit 7, ready bit 0
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module rcf_reset_cause_flags
    import rcf_pkg::*;
#(
    parameter logic BOR_FLAG_INIT = 1'b1 // brown-out flag value after power-on
) (
    input wire logic i_ref_clk, // system clock, 250 mhz
    input wire logic i_rst_b, // power-on reset, active low, async
    input wire logic i_brownout_reset, // brown-out reset level
    input wire logic i_wdt_timeout_reset, // watchdog time-out reset level
    input wire logic i_wdt_window_reset, // watchdog window violation level
    input wire logic i_reset_instr, // reset instruction executed
    input wire logic i_stack_overflow, // stack overflow reset level
    input wire logic i_stack_underflow, // stack underflow reset level
    input wire logic i_mem_violation, // memory execution violation level
    input wire logic i_external_reset_pin_b, // external reset pin, async, low
    input wire logic i_brownout_ready, // brown-out circuit armed, async
    input wire logic i_awvalid, // write address valid
    output logic o_awready, // write address ready
    input wire logic [rcf_pkg::ADDR_W-1:0] i_awaddr, // write byte address
    input wire logic i_wvalid, // write data valid
    output logic o_wready, // write data ready
    input wire logic [rcf_pkg::DATA_W-1:0] i_wdata, // write data
    input wire logic [3:0] i_wstrb, // write strobes
    output logic o_bvalid, // write response valid
    input wire logic i_bready, // write response ready
    output logic [1:0] o_bresp, // write response
    input wire logic i_arvalid, // read address valid
    output logic o_arready, // read address ready
    input wire logic [rcf_pkg::ADDR_W-1:0] i_araddr, // read byte address
    output logic o_rvalid, // read data valid
    input wire logic i_rready, // read data ready
    output logic [rcf_pkg::DATA_W-1:0] o_rdata, // read data
    output logic [1:0] o_rresp, // read response
    output logic o_sw_brownout_enable, // software brown-out enable
    output logic o_irq // level interrupt
);
    logic rst_meta_q;
    logic rst_b_q;
    logic pin_b_s;
    logic bor_rdy_s;
    logic [7:0] flags_q;
    logic [7:0] flags_d;
    logic mem_flag_q;
    logic mem_flag_d;
    logic [7:0] ev_lvl;
    logic [7:0] ev_prev_q;
    logic [7:0] ev_rise;
    logic [7:0] irq_stat_q;
    logic [7:0] irq_en_q;
    logic wr_en;
    logic [9:0] wr_idx;
    logic [7:0] wr_data;
    logic wr_lane0;
    logic [9:0] rd_idx;
    logic [7:0] rd_data;
    logic wr_sel_flags;
    logic wr_sel_ext;
    logic wr_sel_bc;

    // index decode shared by read and write paths
    function automatic logic idx_mapped(input logic [9:0] idx);
        idx_mapped = (idx >= IDX_BROWNOUT_CONTROL) && (idx <= IDX_IRQ_CLEAR);
    endfunction : idx_mapped

    // reset release through two flops; assertion stays asynchronous
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_meta_q <= 1'b0;
            rst_b_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_b_q <= rst_meta_q;
        end
    end

    rcf_sync2 #(.W(2), .RST_VAL(2'b10)) u_sync (
        .i_clk(i_ref_clk),
        .i_rst_b(rst_b_q),
        .i_async({i_external_reset_pin_b, i_brownout_ready}),
        .o_sync({pin_b_s, bor_rdy_s})
    );

    rcf_axil_slave u_bus (
        .i_clk(i_ref_clk),
        .i_rst_b(rst_b_q),
        .i_awvalid(i_awvalid),
        .o_awready(o_awready),
        .i_awaddr(i_awaddr),
        .i_wvalid(i_wvalid),
        .o_wready(o_wready),
        .i_wdata(i_wdata),
        .i_wstrb(i_wstrb),
        .o_bvalid(o_bvalid),
        .i_bready(i_bready),
        .o_bresp(o_bresp),
        .i_arvalid(i_arvalid),
        .o_arready(o_arready),
        .i_araddr(i_araddr),
        .o_rvalid(o_rvalid),
        .i_rready(i_rready),
        .o_rdata(o_rdata),
        .o_rresp(o_rresp),
        .o_wr_en(wr_en),
        .o_wr_idx(wr_idx),
        .o_wr_data(wr_data),
        .o_wr_lane0(wr_lane0),
        .i_wr_hit(idx_mapped(wr_idx)),
        .o_rd_idx(rd_idx),
        .i_rd_data(rd_data),
        .i_rd_hit(idx_mapped(rd_idx))
    );

    assign wr_sel_flags = wr_en & wr_lane0 & (wr_idx == IDX_RESET_CAUSE_FLAGS);
    assign wr_sel_ext = wr_en & wr_lane0 & (wr_idx == IDX_RESET_CAUSE_FLAGS_EXT);
    assign wr_sel_bc = wr_en & wr_lane0 & (wr_idx == IDX_BROWNOUT_CONTROL);

    // flag update: software write first, then the reset cause on top of it;
    // hardware wins a same-cycle clash so a cause is never lost
    always_comb begin
        flags_d = flags_q;
        mem_flag_d = mem_flag_q;
        if (wr_sel_flags) begin
            flags_d = wr_data;
        end
        if (wr_sel_ext) begin
            mem_flag_d = wr_data[BIT_MEM_VIOLATION];
        end
        if (i_brownout_reset) begin
            flags_d = (FLAGS_POR_VAL & FLAGS_BOR_MASK) | (flags_q & ~FLAGS_BOR_MASK);
            flags_d[BIT_BROWNOUT] = 1'b0;
            mem_flag_d = 1'b1;
        end else begin
            // only the matching flag moves; others hold
            if (i_stack_overflow) flags_d[BIT_STACK_OVERFLOW] = 1'b1;
            if (i_stack_underflow) flags_d[BIT_STACK_UNDERFLOW] = 1'b1;
            if (i_wdt_window_reset) flags_d[BIT_WDT_WINDOW] = 1'b0;
            if (i_wdt_timeout_reset) flags_d[BIT_WDT_TIMEOUT] = 1'b0;
            if (!pin_b_s) flags_d[BIT_EXT_PIN] = 1'b0;
            if (i_reset_instr) flags_d[BIT_RESET_INSTR] = 1'b0;
            if (i_mem_violation) mem_flag_d = 1'b0;
        end
    end

    // power-on is the block reset: every flag to its power-on value
    always_ff @(posedge i_ref_clk or negedge rst_b_q) begin
        if (!rst_b_q) begin
            flags_q <= FLAGS_POR_VAL;
            flags_q[BIT_BROWNOUT] <= BOR_FLAG_INIT;
            mem_flag_q <= 1'b1;
        end else begin
            flags_q <= flags_d;
            mem_flag_q <= mem_flag_d;
        end
    end

    // brownout control: software enable, reloaded on power-on and brown-out
    always_ff @(posedge i_ref_clk or negedge rst_b_q) begin
        if (!rst_b_q) begin
            o_sw_brownout_enable <= 1'b1;
        end else if (i_brownout_reset) begin
            o_sw_brownout_enable <= 1'b1;
        end else if (wr_sel_bc) begin
            o_sw_brownout_enable <= wr_data[BIT_SW_BOR_ENABLE];
        end
    end

    // event levels in interrupt status layout
    assign ev_lvl = {i_stack_overflow, i_stack_underflow, i_wdt_window_reset,
                     i_wdt_timeout_reset, ~pin_b_s, i_reset_instr, i_mem_violation,
                     i_brownout_reset};
    assign ev_rise = ev_lvl & ~ev_prev_q;

    // sticky status; a rising cause beats a same-cycle clear
    always_ff @(posedge i_ref_clk or negedge rst_b_q) begin
        if (!rst_b_q) begin
            ev_prev_q <= 8'h00;
            irq_stat_q <= 8'h00;
        end else begin
            ev_prev_q <= ev_lvl;
            if (wr_en && wr_lane0 && wr_idx == IDX_IRQ_CLEAR) begin
                irq_stat_q <= (irq_stat_q & ~wr_data) | ev_rise;
            end else begin
                irq_stat_q <= irq_stat_q | ev_rise;
            end
        end
    end

    // enable register and interrupt line; one flop of lag keeps the output registered
    always_ff @(posedge i_ref_clk or negedge rst_b_q) begin
        if (!rst_b_q) begin
            irq_en_q <= 8'h00;
            o_irq <= 1'b0;
        end else begin
            if (wr_en && wr_lane0 && wr_idx == IDX_IRQ_ENABLE) begin
                irq_en_q <= wr_data;
            end
            o_irq <= |(irq_stat_q & irq_en_q);
        end
    end

    // read mux, byte registers at their indices
    always_comb begin
        case (rd_idx)
            IDX_BROWNOUT_CONTROL: rd_data = {o_sw_brownout_enable, 6'h00, bor_rdy_s};
            IDX_RESET_CAUSE_FLAGS: rd_data = flags_q;
            IDX_RESET_CAUSE_FLAGS_EXT: rd_data = {6'h00, mem_flag_q, 1'b0} & EXT_MASK;
            IDX_IRQ_STATUS: rd_data = irq_stat_q;
            IDX_IRQ_ENABLE: rd_data = irq_en_q;
            default: rd_data = 8'h00; // clear register reads zero
        endcase
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!rst_b_q);

    property p_ovf_set;
        i_stack_overflow && !i_brownout_reset |=> flags_q[BIT_STACK_OVERFLOW];
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");
    property p_unf_set;
        i_stack_underflow && !i_brownout_reset |=> flags_q[BIT_STACK_UNDERFLOW];
    endproperty
    a_unf_set: assert property (p_unf_set) else $error("underflow flag not set");
    property p_wv_clr;
        i_wdt_window_reset && !i_brownout_reset |=> !flags_q[BIT_WDT_WINDOW];
    endproperty
    a_wv_clr: assert property (p_wv_clr) else $error("window flag not cleared");
    property p_wdt_clr;
        i_wdt_timeout_reset && !i_brownout_reset |=> !flags_q[BIT_WDT_TIMEOUT];
    endproperty
    a_wdt_clr: assert property (p_wdt_clr) else $error("timeout flag not cleared");
    property p_pin_clr;
        $fell(i_external_reset_pin_b) ##2 !i_brownout_reset |=> !flags_q[BIT_EXT_PIN];
    endproperty
    a_pin_clr: assert property (p_pin_clr) else $error("pin flag not cleared");
    property p_ri_clr;
        i_reset_instr && !i_brownout_reset |=> !flags_q[BIT_RESET_INSTR];
    endproperty
    a_ri_clr: assert property (p_ri_clr) else $error("instr flag not cleared");
    property p_bor;
        i_brownout_reset |=> !flags_q[BIT_BROWNOUT] && mem_flag_q
            && flags_q[BIT_POWER_ON] == $past(flags_q[BIT_POWER_ON]) && o_sw_brownout_enable;
    endproperty
    a_bor: assert property (p_bor) else $error("brown-out update wrong");
    property p_memory_violation_flag;
        i_mem_violation && !i_brownout_reset |=> !mem_flag_q;
    endproperty
    a_memory_violation_flag: assert property (p_memory_violation_flag) else $error("memory flag not cleared");
    property p_hold;
        !wr_en && !(|ev_lvl) && !i_mem_violation |=> $stable(flags_q) && $stable(mem_flag_q);
    endproperty
    a_hold: assert property (p_hold) else $error("flag moved without cause");
    property p_irq;
        ##1 o_irq == $past(|(irq_stat_q & irq_en_q));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt line mismatch");
    // brown-out reloads every bit above the power-on flag
    property p_bor_vals;
        i_brownout_reset |=> (flags_q & FLAGS_BOR_MASK) == (FLAGS_POR_VAL & FLAGS_BOR_MASK);
    endproperty
    a_bor_vals: assert property (p_bor_vals) else $error("brown-out values wrong");
    // a write with no cause standing lands as written, active levels too
    property p_sw_write;
        wr_sel_flags && !(|ev_lvl) |=> flags_q == $past(wr_data);
    endproperty
    a_sw_write: assert property (p_sw_write) else $error("flag write lost");
    property p_por_keep;
        !wr_sel_flags |=> flags_q[BIT_POWER_ON] == $past(flags_q[BIT_POWER_ON]);
    endproperty
    a_por_keep: assert property (p_por_keep) else $error("power-on flag moved");
    property p_bc_write;
        wr_sel_bc && !i_brownout_reset
            |=> o_sw_brownout_enable == $past(wr_data[BIT_SW_BOR_ENABLE]);
    endproperty
    a_bc_write: assert property (p_bc_write) else $error("enable write lost");
    // status is sticky until cleared, and a rising cause always lands
    property p_stat_keep;
        !(wr_en && wr_lane0 && wr_idx == IDX_IRQ_CLEAR)
            |=> (irq_stat_q & $past(irq_stat_q)) == $past(irq_stat_q);
    endproperty
    a_stat_keep: assert property (p_stat_keep) else $error("status bit lost");
    property p_stat_set;
        (|ev_rise) |=> (irq_stat_q & $past(ev_rise)) == $past(ev_rise);
    endproperty
    a_stat_set: assert property (p_stat_set) else $error("status bit not set");
    c_bor: cover property (i_brownout_reset ##1 !flags_q[BIT_BROWNOUT]);
    c_sw_write: cover property (wr_sel_flags ##1 flags_q == $past(wr_data));
    c_irq: cover property ($rose(o_irq));
    c_pin: cover property (!pin_b_s ##1 !flags_q[BIT_EXT_PIN]);
    c_memory_violation_flag: cover property (i_mem_violation ##1 !mem_flag_q);
endmodule : rcf_reset_cause_flags

// ### src/rcf_sync2.sv
// two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module rcf_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic i_clk, // system clock
    input wire logic i_rst_b, // async reset, active low
    input wire logic [W-1:0] i_async, // level from outside the domain
    output logic [W-1:0] o_sync // synchronised level
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_q <= RST_VAL;
            o_sync <= RST_VAL;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule : rcf_sync2

// ### verif/rcf_reset_cause_flags_tb.sv
// testbench for the reset cause flags block with a reference model
`timescale 1ns/1ps
module rcf_reset_cause_flags_tb;
    import rcf_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] cause = 8'h00; // bit order follows the interrupt status layout
    logic bor_rdy = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [DATA_W-1:0] wdata = '0, rdata;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, sw_en, irq;
    logic [1:0] bresp, rresp;
    logic [7:0] mf, me, bc, st, en, d; // model registers and scratch
    int mismatches = 0, checks = 0, cycles = 0, r;

    always #2 clk = ~clk;

    rcf_reset_cause_flags dut (.i_ref_clk(clk), .i_rst_b(rst_b),
        .i_brownout_reset(cause[0]), .i_mem_violation(cause[1]),
        .i_reset_instr(cause[2]), .i_external_reset_pin_b(~cause[3]),
        .i_wdt_timeout_reset(cause[4]), .i_wdt_window_reset(cause[5]),
        .i_stack_underflow(cause[6]), .i_stack_overflow(cause[7]),
        .i_brownout_ready(bor_rdy), .i_awvalid(awvalid), .o_awready(awready),
        .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
        .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
        .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
        .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
        .o_sw_brownout_enable(sw_en), .o_irq(irq));

    // hang guard, well above the run's length
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            complete_run();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // one write, address and data offered together and released when taken
    task automatic wr(input logic [9:0] idx, input logic [7:0] v, input logic [3:0] s,
                      input logic [1:0] er);
        int n;
        logic a;
        logic w;
        n = 0;
        a = 1'b0;
        w = 1'b0;
        awaddr <= {idx, 2'b00};
        wdata <= {24'($urandom), v};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(a && w) && n < 100) begin
            @(posedge clk);
            n++;
            if (awready) begin
                a = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready) begin
                w = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do begin @(posedge clk); n++; end while (!bvalid && n < 200);
        bready <= 1'b0;
        if (n >= 200) chk("write wait", 32'h0, 32'h1);
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask : wr

    task automatic rd(input logic [9:0] idx, input logic [7:0] ev, input logic [1:0] er,
                      input string name);
        int n;
        n = 0;
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        do begin @(posedge clk); n++; end while (!arready && n < 100);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do begin @(posedge clk); n++; end while (!rvalid && n < 200);
        rready <= 1'b0;
        if (n >= 200) chk("read wait", 32'h0, 32'h1);
        chk(name, {24'h0, ev}, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
    endtask : rd

    task automatic chkall;
        rd(IDX_BROWNOUT_CONTROL, bc, RESP_OKAY, "brownout_control");
        rd(IDX_RESET_CAUSE_FLAGS, mf, RESP_OKAY, "reset_cause_flags");
        rd(IDX_RESET_CAUSE_FLAGS_EXT, me, RESP_OKAY, "reset_cause_flags_ext");
        rd(IDX_IRQ_STATUS, st, RESP_OKAY, "irq status");
        chk("sw enable", {31'h0, bc[7]}, {31'h0, sw_en});
    endtask : chkall

    // power-on restart; extra cycles cover the ready synchroniser
    task automatic por;
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (7) @(posedge clk);
        mf = 8'h3d;
        me = EXT_MASK;
        bc = {1'b1, 6'h00, bor_rdy};
        st = 8'h00;
        en = 8'h00;
    endtask : por

    // a cause level held four cycles covers the pin synchroniser delay
    task automatic fire(input int k);
        cause <= 8'(1 << k);
        repeat (4) @(posedge clk);
        cause <= 8'h00;
        repeat (4) @(posedge clk);
        st[k] = 1'b1;
        if (k == 0) begin
            mf = 8'h3c | (mf & 8'h02);
            me = EXT_MASK;
            bc[7] = 1'b1;
        end else if (k == 1) begin
            me = 8'h00;
        end else begin
            mf[k] = (k >= 6);
        end
    endtask : fire

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    initial begin
        r = $urandom(49);
        @(posedge clk);
        por();
        chkall();
        rd(10'h190, 8'h00, RESP_SLVERR, "unmapped read");
        wr(10'h3ff, 8'hff, 4'hf, RESP_SLVERR);
        wr(IDX_RESET_CAUSE_FLAGS_EXT, 8'hff, 4'hf, RESP_OKAY);
        wr(IDX_IRQ_STATUS, 8'hff, 4'hf, RESP_OKAY);
        wr(IDX_RESET_CAUSE_FLAGS, 8'h00, 4'h0, RESP_OKAY);
        chkall();
        // each cause twice, on random flag contents and a random interrupt mask
        for (int i = 0; i < 16; i++) begin
            mf = 8'($urandom);
            wr(IDX_RESET_CAUSE_FLAGS, mf, 4'hf, RESP_OKAY);
            en = 8'($urandom);
            wr(IDX_IRQ_ENABLE, en, 4'hf, RESP_OKAY);
            d = 8'($urandom);
            wr(IDX_BROWNOUT_CONTROL, d, 4'hf, RESP_OKAY);
            bc[7] = d[7];
            d = 8'($urandom);
            wr(IDX_RESET_CAUSE_FLAGS_EXT, d, 4'hf, RESP_OKAY);
            me = d & EXT_MASK;
            chkall();
            fire(i % 8);
            chkall();
            chk("irq", {31'h0, |(st & en)}, {31'h0, irq});
            rd(IDX_IRQ_ENABLE, en, RESP_OKAY, "irq enable");
            wr(IDX_IRQ_CLEAR, 8'hff, 4'hf, RESP_OKAY);
            st = 8'h00;
            repeat (3) @(posedge clk);
            chk("irq after clear", 32'h0, {31'h0, irq});
            rd(IDX_IRQ_CLEAR, 8'h00, RESP_OKAY, "irq clear");
        end
        // second power-on at the end of the run, ready input low this time
        bor_rdy <= 1'b0;
        por();
        chkall();
        complete_run();
    end
endmodule : rcf_reset_cause_flags_tb
